// >>> design/auto_inverse_toggle.sv
// slow toggle source for the auto-inverse pin function
`timescale 1ns/100ps
`default_nettype none

module auto_inverse_toggle #(
  parameter int unsigned HALF_CYCLES = 1950000
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic run,
  output var  logic toggle_q
);

  localparam int unsigned CNT_W = $clog2(HALF_CYCLES + 1);

  generate
    if (HALF_CYCLES < 2)
    begin : g_bad_half
      $error("auto_inverse_toggle: HALF_CYCLES must be at least 2");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             wrap;
  logic             toggle_d;

  assign wrap     = (cnt_q == CNT_W'(HALF_CYCLES - 1));
  // stopped oscillator: count restarts, so the first half after start lasts the full HALF_CYCLES
  assign cnt_d    = !run ? '0 : (wrap ? '0 : cnt_q + CNT_W'(1));
  assign toggle_d = !run ? 1'b0 : (wrap ? ~toggle_q : toggle_q);

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q    <= '0;
      toggle_q <= 1'b0;
    end
    else
    begin
      cnt_q    <= cnt_d;
      toggle_q <= toggle_d;
    end
  end

endmodule : auto_inverse_toggle

`default_nettype wire

// >>> design/gpio_port.sv
// eight-pin bidirectional port with pull-up, wake-up and auto-inverse
//
// Functional notes
// R1: a pin whose direction bit is one is an input and reads its present level.
// R2: a pin whose direction bit is zero is driven push-pull with its output latch value.
// R3: reading an output pin returns the output latch, not the pin level.
// R4: input levels are sampled at the read; written output data stays until rewritten.
// R5: the pull-up acts only when its enable bit is set and the pin is an input.
// R6: a high-to-low edge on a wake-enabled pin wakes the device from idle or sleep.
// R7: wake-up is honoured only for input pins while the device is in idle or sleep.
// R8: wake-up and direction bits select output, input, auto-inverse or input with wake-up.
// R9: in auto-inverse mode the pin changes state every 15.6 ms from a 32 Hz toggle.
// R10: auto-inverse drives the toggle for data zero and its inverse for data one.
// R11: auto-inverse changes only the pin level, never the stored data bit.
// R12: auto-inverse is inactive while the slow oscillator is stopped.
// R13: the first auto-inverse pulse after enable or data change may be irregular.
// R14: power-on and run-mode watchdog reset load defaults; a sleep watchdog reset keeps them.
// R15: a single-bit set or clear reads the whole port, alters one bit, writes the byte back.
// R16: pin inputs pass two flip-flops before reading and wake-up edge detection.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_params.svh"

module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int unsigned PINS        = 8,
  parameter int unsigned ADDR_W      = 8,
  parameter int unsigned HALF_CYCLES = `GPIO_INV_HALF_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              wdt_reset,
  input  wire logic              low_power,
  input  wire logic              slow_rc_oscillator,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_wr,
  input  wire logic              mem_rd,
  input  wire logic [7:0]        mem_wdata,
  input  wire logic              bit_set,
  input  wire logic              bit_clr,
  input  wire logic [2:0]        bit_sel,
  output var  logic [7:0]        mem_rdata_q,
  input  wire logic [PINS-1:0]   port_pin_in,
  output var  logic [PINS-1:0]   port_pin_out_q,
  output var  logic [PINS-1:0]   port_pin_oe_q,
  output var  logic [PINS-1:0]   pullup_on_q,
  output var  logic              wakeup_q
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  generate
    if (PINS < 1 || PINS > 8)
    begin : g_bad_pins
      $error("gpio_port: PINS must lie between 1 and 8");
    end
    if (ADDR_W < 8)
    begin : g_bad_addr
      $error("gpio_port: ADDR_W must be at least 8");
    end
    if (HALF_CYCLES < 2)
    begin : g_bad_half
      $error("gpio_port: HALF_CYCLES must be at least 2");
    end
  endgenerate

  localparam logic [ADDR_W-1:0] OFS_DATA = ADDR_W'(`GPIO_OFS_DATA);
  localparam logic [ADDR_W-1:0] OFS_DIR  = ADDR_W'(`GPIO_OFS_DIRECTION);
  localparam logic [ADDR_W-1:0] OFS_PU   = ADDR_W'(`GPIO_OFS_PULLUP);
  localparam logic [ADDR_W-1:0] OFS_WU   = ADDR_W'(`GPIO_OFS_WAKEUP);
  localparam logic [PINS-1:0]   RST_DATA = PINS'(`GPIO_RST_DATA);
  localparam logic [PINS-1:0]   RST_DIR  = PINS'(`GPIO_RST_DIRECTION);
  localparam logic [PINS-1:0]   RST_PU   = PINS'(`GPIO_RST_PULLUP);
  localparam logic [PINS-1:0]   RST_WU   = PINS'(`GPIO_RST_WAKEUP);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [PINS-1:0] port_pin_data_q;
  logic [PINS-1:0] port_pin_data_d;
  logic [PINS-1:0] pin_direction_bits_q;
  logic [PINS-1:0] pin_direction_bits_d;
  logic [PINS-1:0] pullup_enable_bits_q;
  logic [PINS-1:0] pullup_enable_bits_d;
  logic [PINS-1:0] wakeup_enable_bits_q;
  logic [PINS-1:0] wakeup_enable_bits_d;

  // ****************************************************************
  // pin input synchronisers
  // ****************************************************************
  logic [PINS-1:0] pin_meta_q;
  logic [PINS-1:0] pin_sync_q;
  logic [PINS-1:0] pin_prev_q;

  // R16 two-stage synchroniser
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_meta_q <= '1;
      pin_sync_q <= '1;
      pin_prev_q <= '1;
    end
    else
    begin
      pin_meta_q <= port_pin_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic hit_data;
  logic hit_dir;
  logic hit_pu;
  logic hit_wu;
  logic hit_any;

  assign hit_data = (mem_addr == OFS_DATA);
  assign hit_dir  = (mem_addr == OFS_DIR);
  assign hit_pu   = (mem_addr == OFS_PU);
  assign hit_wu   = (mem_addr == OFS_WU);
  assign hit_any  = hit_data | hit_dir | hit_pu | hit_wu;

  reg_sel_e sel;

  assign sel = hit_data ? SEL_DATA :
               hit_dir  ? SEL_DIRECTION :
               hit_pu   ? SEL_PULLUP :
               hit_wu   ? SEL_WAKEUP : SEL_NONE;

  // ****************************************************************
  // read value of the port
  // ****************************************************************
  logic [PINS-1:0] port_view;

  // R1 R3 R4 inputs sampled now, outputs read the latch
  assign port_view = (pin_direction_bits_q & pin_sync_q) |
                     (~pin_direction_bits_q & port_pin_data_q);

  logic [7:0] read_val;

  assign read_val = (sel == SEL_DATA)      ? 8'(port_view) :
                    (sel == SEL_DIRECTION) ? 8'(pin_direction_bits_q) :
                    (sel == SEL_PULLUP)    ? 8'(pullup_enable_bits_q) :
                    (sel == SEL_WAKEUP)    ? 8'(wakeup_enable_bits_q) : 8'h00;

  // ****************************************************************
  // write value, byte or single bit
  // ****************************************************************
  logic [7:0] bit_mask;
  logic [7:0] rmw_val;
  logic       bit_op;
  logic       do_write;
  logic [7:0] write_val;

  assign bit_mask = 8'h01 << bit_sel;
  assign bit_op   = bit_set | bit_clr;

  // R15 whole byte read, one bit altered, byte written back
  assign rmw_val   = bit_set ? (read_val | bit_mask) : (read_val & ~bit_mask);
  assign do_write  = (mem_wr | bit_op) & hit_any;
  assign write_val = bit_op ? rmw_val : mem_wdata;

  // ****************************************************************
  // watchdog reset qualification
  // ****************************************************************
  logic wdt_clear;

  // R14 only a run-mode watchdog reset restores defaults
  assign wdt_clear = wdt_reset & ~low_power;

  // ****************************************************************
  // per-register write enables
  // ****************************************************************
  logic wr_data;
  logic wr_dir;
  logic wr_pu;
  logic wr_wu;

  assign wr_data = do_write & (sel == SEL_DATA);
  assign wr_dir  = do_write & (sel == SEL_DIRECTION);
  assign wr_pu   = do_write & (sel == SEL_PULLUP);
  assign wr_wu   = do_write & (sel == SEL_WAKEUP);

  // R4 latch holds until written again
  // run-mode watchdog reset wins, a write in that cycle is lost
  assign port_pin_data_d      = wdt_clear ? RST_DATA :
                                wr_data   ? PINS'(write_val) :
                                            port_pin_data_q;
  assign pin_direction_bits_d = wdt_clear ? RST_DIR :
                                wr_dir    ? PINS'(write_val) :
                                            pin_direction_bits_q;
  assign pullup_enable_bits_d = wdt_clear ? RST_PU :
                                wr_pu     ? PINS'(write_val) :
                                            pullup_enable_bits_q;
  assign wakeup_enable_bits_d = wdt_clear ? RST_WU :
                                wr_wu     ? PINS'(write_val) :
                                            wakeup_enable_bits_q;

  // R14 power-on defaults, all pins inputs
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port_pin_data_q      <= RST_DATA;
      pin_direction_bits_q <= RST_DIR;
    end
    else
    begin
      port_pin_data_q      <= port_pin_data_d;
      pin_direction_bits_q <= pin_direction_bits_d;
    end
  end

  // R14 pull-ups and wake-ups start disabled
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pullup_enable_bits_q <= RST_PU;
      wakeup_enable_bits_q <= RST_WU;
    end
    else
    begin
      pullup_enable_bits_q <= pullup_enable_bits_d;
      wakeup_enable_bits_q <= wakeup_enable_bits_d;
    end
  end

  // ****************************************************************
  // read data register
  // ****************************************************************
  logic [7:0] rdata_d;

  // unmapped offsets and idle cycles read as zero
  assign rdata_d = (mem_rd && hit_any) ? read_val : 8'h00;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_rdata_q <= 8'h00;
    end
    else
    begin
      mem_rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // auto-inverse toggle source
  // ****************************************************************
  logic inverse_toggle_signal;

  // R9 R12 R13 toggle every half period, held low while oscillator stops
  auto_inverse_toggle #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_toggle (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .run      (slow_rc_oscillator),
    .toggle_q (inverse_toggle_signal)
  );

  // ****************************************************************
  // per-pin function
  // ****************************************************************
  logic [PINS-1:0] drive_d;
  logic [PINS-1:0] oe_d;
  logic [PINS-1:0] pullup_d;
  logic [PINS-1:0] wake_edge;

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi = gi + 1)
    begin : g_pin
      pin_mode_e mode;
      logic      auto_inv;
      logic      fall;

      // R8 function from wake-up and direction pair
      assign mode = pin_mode_e'({wakeup_enable_bits_q[gi], pin_direction_bits_q[gi]});

      // R12 stopped oscillator leaves a plain output
      assign auto_inv = (mode == MODE_AUTO_INV) & slow_rc_oscillator;

      // R2 push-pull output whenever direction is zero
      assign oe_d[gi] = ~pin_direction_bits_q[gi];

      // R10 R11 toggle xor data, latch untouched
      assign drive_d[gi] = auto_inv ? (inverse_toggle_signal ^ port_pin_data_q[gi]) :
                                      port_pin_data_q[gi];

      // R5 weak pull-up only on input pins
      assign pullup_d[gi] = pullup_enable_bits_q[gi] & pin_direction_bits_q[gi];

      // R16 edge seen after synchroniser only
      assign fall = pin_prev_q[gi] & ~pin_sync_q[gi];

      // R6 R7 wake on falling edge of an input with wake-up in low power
      assign wake_edge[gi] = fall & (mode == MODE_INPUT_WAKE) & low_power;
    end
  endgenerate

  // ****************************************************************
  // pin drive and wake-up outputs
  // ****************************************************************
  logic wakeup_d;

  assign wakeup_d = |wake_edge;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port_pin_out_q <= '0;
      port_pin_oe_q  <= '0;
      pullup_on_q    <= '0;
    end
    else
    begin
      port_pin_out_q <= drive_d;
      port_pin_oe_q  <= oe_d;
      pullup_on_q    <= pullup_d;
    end
  end

  // R6 wake request lasts one cycle per falling edge
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wakeup_q <= 1'b0;
    end
    else
    begin
      wakeup_q <= wakeup_d;
    end
  end

endmodule : gpio_port

`default_nettype wire

// >>> design/gpio_port_params.svh
// constants of the eight-pin port: offsets, reset values and timing
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

// ****************************************************************
// data-memory offsets of the port registers
// ****************************************************************
`define GPIO_OFS_DATA       8'h12
`define GPIO_OFS_DIRECTION  8'h13
`define GPIO_OFS_PULLUP     8'h14
`define GPIO_OFS_WAKEUP     8'h15

// ****************************************************************
// reset values
// ****************************************************************
`define GPIO_RST_DATA       8'hff
`define GPIO_RST_DIRECTION  8'hff
`define GPIO_RST_PULLUP     8'h00
`define GPIO_RST_WAKEUP     8'h00

// ****************************************************************
// auto-inverse timing
// ****************************************************************
`define GPIO_INV_FREQ_HZ       32
`define GPIO_INV_HALF_PERIOD_US 15600
`define GPIO_MCLK_PERIOD_NS    8
`define GPIO_INV_HALF_CYCLES   ((`GPIO_INV_HALF_PERIOD_US * 1000) / `GPIO_MCLK_PERIOD_NS)

`endif

// >>> design/gpio_port_pkg.sv
// types shared by the port logic
`default_nettype none
package gpio_port_pkg;

  // per-pin function, indexed by {wake-up bit, direction bit}
  typedef enum logic [1:0] {
    MODE_OUTPUT     = 2'b00,
    MODE_INPUT      = 2'b01,
    MODE_AUTO_INV   = 2'b10,
    MODE_INPUT_WAKE = 2'b11
  } pin_mode_e;

  // register selected by a data-memory access
  typedef enum logic [2:0] {
    SEL_NONE      = 3'b000,
    SEL_DATA      = 3'b001,
    SEL_DIRECTION = 3'b010,
    SEL_PULLUP    = 3'b011,
    SEL_WAKEUP    = 3'b100
  } reg_sel_e;

endpackage : gpio_port_pkg
`default_nettype wire

// >>> verif/gpio_port_props.sv
// concurrent checks on the port block's pins and register bus
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_params.svh"

module gpio_port_props
  import gpio_port_pkg::*;
#(
  parameter int unsigned PINS        = 8,
  parameter int unsigned ADDR_W      = 8,
  parameter int unsigned HALF_CYCLES = 8
) (
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              wdt_reset,
  input wire logic              low_power,
  input wire logic              slow_rc_oscillator,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              mem_wr,
  input wire logic              mem_rd,
  input wire logic [7:0]        mem_wdata,
  input wire logic              bit_set,
  input wire logic              bit_clr,
  input wire logic [2:0]        bit_sel,
  input wire logic [7:0]        mem_rdata_q,
  input wire logic [PINS-1:0]   port_pin_in,
  input wire logic [PINS-1:0]   port_pin_out_q,
  input wire logic [PINS-1:0]   port_pin_oe_q,
  input wire logic [PINS-1:0]   pullup_on_q,
  input wire logic              wakeup_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic mapped;
  logic wr_any;
  assign mapped = mem_addr >= ADDR_W'(`GPIO_OFS_DATA) && mem_addr <= ADDR_W'(`GPIO_OFS_WAKEUP);
  assign wr_any = mem_wr | bit_set | bit_clr;
  // ****************************************************************
  // assertions and cover points
  // ****************************************************************
  property p_rd_zero;
    (!mem_rd || !mapped) |=> mem_rdata_q == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
  property p_dir_oe;
    (mem_wr && !bit_set && !bit_clr && !wdt_reset && mem_addr == ADDR_W'(`GPIO_OFS_DIRECTION))
      ##1 !wdt_reset |=> port_pin_oe_q == ~$past(mem_wdata, 2);
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("enable not from direction");
  property p_pull_in;
    (pullup_on_q & port_pin_oe_q) == '0;
  endproperty
  a_pull_in: assert property (p_pull_in) else $error("pull-up on driven pin");
  property p_wake_lp;
    wakeup_q |-> $past(low_power);
  endproperty
  a_wake_lp: assert property (p_wake_lp) else $error("wake while running");
  property p_wake_fall;
    wakeup_q |-> ($past(port_pin_in, 4) & ~$past(port_pin_in, 3)) != '0;
  endproperty
  a_wake_fall: assert property (p_wake_fall) else $error("wake without fall");
  property p_wdt_run;
    wdt_reset && !low_power |-> ##2 (port_pin_oe_q == '0 && pullup_on_q == '0);
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("run reset not default");
  property p_wdt_keep;
    wdt_reset && low_power && !wr_any |-> ##2 $stable(port_pin_oe_q);
  endproperty
  a_wdt_keep: assert property (p_wdt_keep) else $error("sleep reset changed pins");
  property p_out_hold;
    (!wr_any && !wdt_reset && !slow_rc_oscillator)[*4] |-> $stable(port_pin_out_q);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("pin moved while idle");
  c_wake: cover property (wakeup_q);
  c_rd_data: cover property (mem_rd && mem_addr == ADDR_W'(`GPIO_OFS_DATA));
  c_toggle: cover property (slow_rc_oscillator && $changed(port_pin_out_q));
endmodule : gpio_port_props

bind gpio_port gpio_port_props #(.PINS(PINS), .ADDR_W(ADDR_W), .HALF_CYCLES(HALF_CYCLES)) u_props (
  .mclk(mclk), .rst_b(rst_b), .wdt_reset(wdt_reset), .low_power(low_power),
  .slow_rc_oscillator(slow_rc_oscillator), .mem_addr(mem_addr), .mem_wr(mem_wr),
  .mem_rd(mem_rd), .mem_wdata(mem_wdata), .bit_set(bit_set), .bit_clr(bit_clr),
  .bit_sel(bit_sel), .mem_rdata_q(mem_rdata_q), .port_pin_in(port_pin_in),
  .port_pin_out_q(port_pin_out_q), .port_pin_oe_q(port_pin_oe_q),
  .pullup_on_q(pullup_on_q), .wakeup_q(wakeup_q)
);
`default_nettype wire

// >>> verif/pin_load.sv
// external circuitry on the pins: switches, weak pull-ups, floating lines
`timescale 1ns/100ps
`default_nettype none

module pin_load (
  input  wire logic       mclk,
  input  wire logic [7:0] drv_val,
  input  wire logic [7:0] drv_oe,
  input  wire logic [7:0] pull_on,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output var  logic [7:0] level
);
  logic [7:0] float_q;
  // undriven lines wander so a stale level never passes
  always @(posedge mclk) float_q <= (float_q === 8'h55) ? 8'haa : 8'h55;
  // weak pull-up only where nobody drives
  always_comb
    for (int i = 0; i < 8; i++)
      level[i] = drv_oe[i] ? drv_val[i] : ext_en[i] ? ext_val[i] : pull_on[i] ? 1'b1 : float_q[i];
endmodule : pin_load
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the eight-pin port
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_params.svh"

module testbench;
  import gpio_port_pkg::*;
  localparam int unsigned HC = 8;
  localparam logic [7:0]  AD = `GPIO_OFS_DATA;
  localparam logic [7:0]  AR = `GPIO_OFS_DIRECTION;
  localparam logic [7:0]  AP = `GPIO_OFS_PULLUP;
  localparam logic [7:0]  AW = `GPIO_OFS_WAKEUP;
  logic       mclk, rst_b, wdt_reset, low_power, slow_rc_oscillator, mem_wr, mem_rd;
  logic       bit_set, bit_clr, wakeup_q;
  logic [2:0] bit_sel;
  logic [7:0] mem_addr, mem_wdata, mem_rdata_q, port_pin_in, port_pin_out_q;
  logic [7:0] port_pin_oe_q, pullup_on_q, ext_val, ext_en;
  int         mismatches, checks_done, h;

  gpio_port #(.HALF_CYCLES(HC)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .wdt_reset(wdt_reset), .low_power(low_power),
    .slow_rc_oscillator(slow_rc_oscillator), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata), .bit_set(bit_set), .bit_clr(bit_clr),
    .bit_sel(bit_sel), .mem_rdata_q(mem_rdata_q), .port_pin_in(port_pin_in),
    .port_pin_out_q(port_pin_out_q), .port_pin_oe_q(port_pin_oe_q),
    .pullup_on_q(pullup_on_q), .wakeup_q(wakeup_q));
  pin_load u_load (.mclk(mclk), .drv_val(port_pin_out_q), .drv_oe(port_pin_oe_q),
    .pull_on(pullup_on_q), .ext_val(ext_val), .ext_en(ext_en), .level(port_pin_in));

  // ****************************************************************
  // bus and check helpers
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge mclk);
    mem_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string m);
    @(posedge mclk);
    mem_addr <= a;
    mem_rd <= 1'b1;
    @(posedge mclk);
    mem_rd <= 1'b0;
    #1;
    chk(mem_rdata_q, exp, m);
  endtask : rd
  task automatic bop(input logic [7:0] a, input logic [2:0] s, input logic set);
    @(posedge mclk);
    mem_addr <= a;
    bit_sel <= s;
    bit_set <= set;
    bit_clr <= !set;
    @(posedge mclk);
    bit_set <= 1'b0;
    bit_clr <= 1'b0;
  endtask : bop
  task automatic fall(input logic [7:0] p, input int exp);
    @(posedge mclk);
    ext_val <= p;
    h = 0;
    repeat (8)
    begin
      cyc(1);
      if (wakeup_q === 1'b1) h++;
    end
    chk(8'(h), 8'(exp), "wake count");
  endtask : fall
  task automatic wdt_pulse;
    @(posedge mclk);
    wdt_reset <= 1'b1;
    @(posedge mclk);
    wdt_reset <= 1'b0;
    cyc(2);
  endtask : wdt_pulse

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    wr(8'h11, 8'h00);
    rd(AD, 8'h5a, "input level");
    rd(AR, 8'hff, "dir reset");
    rd(AP, 8'h00, "pull reset");
    rd(AW, 8'h00, "wake reset");
    rd(8'h16, 8'h00, "unmapped");
    chk(port_pin_oe_q, 8'h00, "oe reset");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_out;
    wr(AR, 8'h0f);
    wr(AD, 8'ha5);
    cyc(2);
    chk(port_pin_oe_q, 8'hf0, "oe");
    chk(port_pin_out_q & 8'hf0, 8'ha0, "drive");
    rd(AD, 8'haa, "mixed read");
    ext_val <= 8'h53;
    cyc(3);
    rd(AD, 8'ha3, "live read");
    wr(AP, 8'hff);
    cyc(2);
    chk(pullup_on_q, 8'h0f, "pull inputs only");
    ext_en <= 8'hf0;
    cyc(3);
    rd(AD, 8'haf, "pulled high");
    ext_en <= 8'hff;
    cyc(3);
    $display("t_out done");
  endtask : t_out
  task automatic t_bitop;
    bop(AD, 3'd7, 1'b0);
    wr(AR, 8'h00);
    cyc(2);
    chk(port_pin_out_q, 8'h23, "modify write");
    bop(AR, 3'd7, 1'b1);
    rd(AR, 8'h80, "bit set");
    $display("t_bitop done");
  endtask : t_bitop
  task automatic t_inv;
    int n;
    logic b;
    wr(AR, 8'h00);
    wr(AW, 8'h01);
    @(posedge mclk);
    slow_rc_oscillator <= 1'b1;
    cyc(1);
    b = port_pin_out_q[0];
    for (n = 0; n < 4 * HC && port_pin_out_q[0] === b; n++) cyc(1);
    b = port_pin_out_q[0];
    for (n = 0; n < 4 * HC && port_pin_out_q[0] === b; n++) cyc(1);
    chk(8'(n), 8'(HC), "half period");
    b = port_pin_out_q[0];
    rd(AD, 8'h23, "latch kept");
    wr(AD, 8'h22);
    cyc(1);
    chk({7'h0, port_pin_out_q[0]}, {7'h0, ~b}, "data inverts");
    @(posedge mclk);
    slow_rc_oscillator <= 1'b0;
    cyc(4);
    chk(port_pin_out_q, 8'h22, "osc stopped");
    cyc(2 * HC);
    chk(port_pin_out_q, 8'h22, "no toggle");
    $display("t_inv done");
  endtask : t_inv
  task automatic t_wake;
    ext_val <= 8'hff;
    wr(AW, 8'hff);
    wr(AR, 8'hfe);
    @(posedge mclk);
    low_power <= 1'b1;
    cyc(4);
    fall(8'hf7, 1);
    fall(8'hff, 0);
    @(posedge mclk);
    low_power <= 1'b0;
    fall(8'hef, 0);
    fall(8'hff, 0);
    wr(AW, 8'h00);
    @(posedge mclk);
    low_power <= 1'b1;
    fall(8'hdf, 0);
    $display("t_wake done");
  endtask : t_wake
  task automatic t_wdt;
    wdt_pulse();
    rd(AR, 8'hfe, "sleep keep");
    @(posedge mclk);
    low_power <= 1'b0;
    wdt_pulse();
    rd(AR, 8'hff, "dir default");
    rd(AW, 8'h00, "wake default");
    rd(AP, 8'h00, "pull default");
    wr(AR, 8'h00);
    cyc(2);
    chk(port_pin_out_q, 8'hff, "data default");
    $display("t_wdt done");
  endtask : t_wdt

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // tests need well under 1000 cycles
  initial
  begin
    #100us;
    mismatches++;
    close_out();
  end
  initial
  begin
    {rst_b, wdt_reset, low_power, slow_rc_oscillator, mem_wr, mem_rd, bit_set, bit_clr} = '0;
    bit_sel = 3'h0;
    mem_addr = 8'h00;
    mem_wdata = 8'h00;
    ext_val = 8'h5a;
    ext_en = 8'hff;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    cyc(3);
    t_reset();
    t_out();
    t_bitop();
    t_inv();
    t_wake();
    t_wdt();
    close_out();
  end
endmodule : testbench
`default_nettype wire
